/* File: pkg/opmode_pkg.sv */
package opmode_pkg;

   // ----------------------------------------
   // Mode encodings {background, b, a}
   // ----------------------------------------
   typedef enum logic [2:0] {
      MODE_SPECIAL_SINGLE = 3'h0,
      MODE_SPECIAL_NARROW = 3'h1,
      MODE_SPECIAL_PERIPH = 3'h2,
      MODE_SPECIAL_WIDE = 3'h3,
      MODE_NORMAL_SINGLE = 3'h4,
      MODE_NORMAL_NARROW = 3'h5,
      MODE_RESERVED = 3'h6,
      MODE_NORMAL_WIDE = 3'h7
   } mode_type;

   // ----------------------------------------
   // Register map of this block
   // ----------------------------------------
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;

   // Mode register fields
   localparam int BIT_SPECIAL_N = 7;
   localparam int BIT_MODE_B = 6;
   localparam int BIT_MODE_A = 5;
   localparam int BIT_STRETCH = 4;
   localparam int BIT_EMK = 1;
   localparam int BIT_EME = 0;

   // Status register fields
   localparam int BIT_SINGLE = 0;
   localparam int BIT_NARROW = 1;
   localparam int BIT_WIDE_BUS = 2;
   localparam int BIT_PERIPH = 3;
   localparam int BIT_DEBUG = 4;
   localparam int BIT_AB_MAP = 5;
   localparam int BIT_E_MAP = 6;
   localparam int BIT_K_MAP = 7;

   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   // Decoded configuration
   typedef struct packed {
      logic singleChip;
      logic narrowBus;
      logic wideBus;
      logic periph;
      logic special;
   } mode_cfg_type;

endpackage

/* File: src/operating_mode_select.sv */
`timescale 1ns/1ps
// What this block does
// - Mode chosen at reset exit from background and two mode pins.
// - Strap levels captured into special and mode bits at reset release.
// - Eight-way decode of the three straps; reserved forced to peripheral.
// - Single-chip modes drive no external bus; ports A, B are GPIO.
// - Wide and peripheral modes: A and B carry multiplexed 16-bit bus.
// - Narrow modes: A and B carry address, A alone carries 8-bit data.
// - Narrow 16-bit transfer uses two cycles, high byte then low.
// - Second narrow cycle presents the address plus one.
// - Normal modes protect control bits, write-once.
// - Special modes relax protection for test software.
// - Special single-chip enters active background debug at once.
// - Peripheral mode holds processor inactive, external master drives bus.
// - Peripheral mode cannot be entered or left except through reset.
// - Expanded and peripheral modes remove port A and B registers.
// - Port E registers removed in peripheral, or expanded with emulation bit.
// - Port K registers removed in peripheral, or expanded with emulation bit.
// - Unimplemented reads return zero.
// - Special bit writable only in special modes, first write ignored.
// - Mode bits write once normal, any but first special; never peripheral.
// - Clock stretch enable reads one in expanded modes.
module operating_mode_select
   import opmode_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Strap pins
   input wire logic background_strap_pin,
   input wire logic mode_select_b,
   input wire logic mode_select_a,
   // Register port
   input wire opmode_pkg::bus_req_type busReq,
   output logic [7:0] rdata,
   // Debug handshake from the debug host
   input wire logic debugEnableCmd,
   input wire logic debugActivateCmd,
   // External bus request from the core
   input wire logic xferStart,
   input wire logic xferWide,
   input wire logic [15:0] xferAddr,
   input wire logic [15:0] xferData,
   // Port pins
   output logic [7:0] portAOut,
   output logic [7:0] portBOut,
   output logic portAOe,
   output logic portBOe,
   output logic xferBusy,
   // Configuration outputs
   output opmode_pkg::mode_cfg_type modeCfg,
   output logic cpuHalt,
   output logic background_debug_mode,
   output logic portAbInMap,
   output logic portEInMap,
   output logic portKInMap,
   output logic clock_stretch_enable
);
   import opmode_pkg::*;

   // ----------------------------------------
   // Register layout
   // ----------------------------------------
   // Mode register at offset zero:
   //   bit 7 special select, low in special modes
   //   bits 6 and 5 mode select b and a
   //   bit 4 clock stretch enable
   //   bits 3 and 2 read as zero
   //   bit 1 port K emulation
   //   bit 0 port E emulation
   // Status register at offset one:
   //   bit 0 single-chip
   //   bit 1 narrow expanded bus
   //   bit 2 wide multiplexed bus
   //   bit 3 peripheral mode
   //   bit 4 background debug active
   //   bit 5 ports A and B in map
   //   bit 6 port E in map
   //   bit 7 port K in map
   // Mode register leaves the map in peripheral mode
   // Unmapped reads return zero
   //
   // Hazards
   //   Mode writes act one cycle later in modeCfg
   //   Transfers started while busy are dropped, except in the last data phase
   //   Transfer width sampled only at the start
   //   Narrow transfers of one byte use the high byte only
   //   Emulation bits load one cycle after reset release
   //   Control bits share one first-write tracker
   //   Debug activation needs a prior enable

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Turns a three-bit mode code into bus, peripheral and special flags
   // Used for the live mode and for requested writes
   // Reserved code behaves as peripheral mode
   function automatic mode_cfg_type decodeMode(input logic [2:0] m);
      mode_cfg_type c;
      c = '0;
      c.special = ~m[2];
      case (m)
         MODE_NORMAL_SINGLE, MODE_SPECIAL_SINGLE: c.singleChip = 1'b1;
         MODE_NORMAL_NARROW, MODE_SPECIAL_NARROW: c.narrowBus = 1'b1;
         MODE_NORMAL_WIDE, MODE_SPECIAL_WIDE: c.wideBus = 1'b1;
         default: begin
            c.periph = 1'b1;
            c.wideBus = 1'b1;
            c.special = 1'b1;
         end
      endcase
      return c;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   // Write-once trackers, debug flags, transfer holds
   // Transfer phases: address, data, next address, last data
   typedef enum logic [1:0] {XFER_IDLE, XFER_HIGH, XFER_LOW, XFER_TAIL} xfer_type;

   logic inReset;
   logic [2:0] modeBits;
   logic specialWritten;
   logic modeWritten;
   logic stretch;
   logic emulate_port_k_bit;
   logic emulate_port_e_bit;
   logic ctrlWritten;
   logic debugEnabled;
   xfer_type xferState;
   logic [15:0] xferAddrHold;
   logic [15:0] xferDataHold;
   logic xferWideHold;

   // ----------------------------------------
   // Combinational decode
   // ----------------------------------------
   // Write legality and next-state terms
   // Peripheral mode blocks every mode register write
   wire mode_cfg_type cfg = decodeMode(modeBits);
   wire expanded = cfg.narrowBus | (cfg.wideBus & ~cfg.periph);
   wire modeWrite = busReq.wr && busReq.addr == ADDR_MODE && !cfg.periph;
   wire [2:0] reqMode = {busReq.wdata[BIT_SPECIAL_N], busReq.wdata[BIT_MODE_B], busReq.wdata[BIT_MODE_A]};
   // Decode of the requested mode for the legality test
   wire mode_cfg_type reqCfg = decodeMode(reqMode);
   wire reqModeOk = !reqCfg.periph;
   // Special bit: only in special modes, first write ignored
   wire specialWrOk = modeWrite && cfg.special && specialWritten;
   // Mode bits: once in normal, any but first in special
   wire modeBitsWrOk = modeWrite && reqModeOk && (cfg.special ? modeWritten : !modeWritten);
   // Control bits: write-once normal, any but first special
   wire ctrlWrOk = modeWrite && (cfg.special ? ctrlWritten : !ctrlWritten);
   wire [2:0] next_modeBits = {specialWrOk ? busReq.wdata[BIT_SPECIAL_N] : modeBits[2],
                               modeBitsWrOk ? reqMode[1:0] : modeBits[1:0]};
   // Map flags and stretch readback
   // Ports A and B only mapped in single-chip
   // Ports E and K leave in peripheral, or expanded with emulation
   wire stretchRead = stretch | expanded;
   wire abMap = cfg.singleChip;
   wire eMap = !(cfg.periph || (expanded && emulate_port_e_bit));
   wire kMap = !(cfg.periph || (expanded && emulate_port_k_bit));

   // Read images of the two registers
   wire [7:0] modeReg = {modeBits, stretchRead, 2'b00, emulate_port_k_bit, emulate_port_e_bit};
   wire [7:0] statusReg = {kMap, eMap, abMap, background_debug_mode, cfg.periph,
                           cfg.wideBus, cfg.narrowBus, cfg.singleChip};
   // Read selection, registered below
   logic [7:0] next_rdata;
   always_comb begin
      if (busReq.addr == ADDR_MODE && !cfg.periph) begin
         next_rdata = modeReg;
      end else if (busReq.addr == ADDR_STATUS) begin
         next_rdata = statusReg;
      end else begin
         next_rdata = UNMAPPED_READ;
      end
   end

   // ----------------------------------------
   // Strap capture and mode register
   // ----------------------------------------
   // Straps followed while reset is high
   // Mode bits then change only by legal writes
   always_ff @(posedge clk) begin
      inReset <= sys_rst;
      if (sys_rst) begin
         // Straps followed through reset, frozen at release
         modeBits <= {background_strap_pin, mode_select_b, mode_select_a};
         specialWritten <= 1'b0;
         modeWritten <= 1'b0;
         ctrlWritten <= 1'b0;
      end else begin
         modeBits <= next_modeBits;
         // Special writes counted for the first-write rule
         if (modeWrite && cfg.special) begin
            specialWritten <= 1'b1;
         end
         // Any mode register write outside peripheral mode, even an ignored one, closes the write-once window
         if (modeWrite) begin
            modeWritten <= 1'b1;
            ctrlWritten <= 1'b1;
         end
      end
   end

   // Control bits; emulation reset values follow the captured mode, stretch resets to one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stretch <= 1'b1;
         emulate_port_k_bit <= 1'b0;
         emulate_port_e_bit <= 1'b0;
      end else if (inReset) begin
         // Emulation bits default set in special modes
         emulate_port_k_bit <= cfg.special;
         emulate_port_e_bit <= cfg.special;
      end else if (ctrlWrOk) begin
         // Permitted control write
         stretch <= busReq.wdata[BIT_STRETCH];
         emulate_port_k_bit <= busReq.wdata[BIT_EMK];
         emulate_port_e_bit <= busReq.wdata[BIT_EME];
      end
   end

   // ----------------------------------------
   // Background debug
   // ----------------------------------------
   // Special single-chip wakes up with debug active
   // Other modes need an enable, then an activate
   // Peripheral mode ignores the host to avoid bus clashes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         debugEnabled <= 1'b0;
         background_debug_mode <= 1'b0;
      end else if (inReset && modeBits == MODE_SPECIAL_SINGLE) begin
         debugEnabled <= 1'b1;
         background_debug_mode <= 1'b1;
      end else if (!cfg.periph) begin
         // Host enable step
         if (debugEnableCmd) begin
            debugEnabled <= 1'b1;
         end
         // Activation only once enabled
         if (debugActivateCmd && debugEnabled) begin
            background_debug_mode <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // External bus sequencer
   // ----------------------------------------
   // Drives the multiplexed bus on ports A and B
   // Wide: address, then both data bytes
   // Narrow: address, high byte, address plus one, low byte
   // Enables drop in the cycle after the last phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xferState <= XFER_IDLE;
         xferAddrHold <= 16'h0000;
         xferDataHold <= 16'h0000;
         xferWideHold <= 1'b0;
         portAOut <= 8'h00;
         portBOut <= 8'h00;
         portAOe <= 1'b0;
         portBOe <= 1'b0;
      end else begin
         case (xferState)
            // Idle: pins released, wait for a start
            XFER_IDLE: begin
               portAOe <= 1'b0;
               portBOe <= 1'b0;
               if (xferStart && !cfg.singleChip && !cfg.periph) begin
                  xferAddrHold <= xferAddr;
                  xferDataHold <= xferData;
                  xferWideHold <= xferWide;
                  portAOut <= xferAddr[15:8];
                  portBOut <= xferAddr[7:0];
                  portAOe <= 1'b1;
                  portBOe <= 1'b1;
                  xferState <= XFER_HIGH;
               end
            end
            // First data phase
            XFER_HIGH: begin
               if (cfg.narrowBus) begin
                  // Narrow: high byte on A, B keeps the address
                  portAOut <= xferDataHold[15:8];
                  xferState <= (xferWideHold) ? XFER_LOW : XFER_IDLE;
                  if (xferWideHold) begin
                     xferAddrHold <= xferAddrHold + 16'h0001;
                  end
               end else begin
                  // Wide: both bytes at once
                  portAOut <= xferDataHold[15:8];
                  portBOut <= xferDataHold[7:0];
                  xferState <= XFER_IDLE;
               end
            end
            // Second narrow address phase
            XFER_LOW: begin
               portAOut <= xferAddrHold[15:8];
               portBOut <= xferAddrHold[7:0];
               xferDataHold <= {xferDataHold[7:0], 8'h00};
               xferState <= XFER_TAIL;
            end
            // Low byte on A, then release
            XFER_TAIL: begin
               portAOut <= xferDataHold[15:8];
               xferState <= XFER_IDLE;
            end
            default: xferState <= XFER_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Every output leaves a flip-flop
   // Config and map flags lag the live mode by a cycle
   // Read data stands one cycle after the strobe, else zero
   // Busy rises the cycle after the start and covers every phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= 8'h00;
         modeCfg <= '0;
         cpuHalt <= 1'b0;
         portAbInMap <= 1'b1;
         portEInMap <= 1'b1;
         portKInMap <= 1'b1;
         clock_stretch_enable <= 1'b1;
         xferBusy <= 1'b0;
      end else begin
         rdata <= busReq.rd ? next_rdata : 8'h00;
         modeCfg <= cfg;
         cpuHalt <= cfg.periph;
         portAbInMap <= abMap;
         portEInMap <= eMap;
         portKInMap <= kMap;
         clock_stretch_enable <= stretchRead;
         xferBusy <= (xferState != XFER_IDLE) || xferStart;
      end
   end

endmodule

/* File: tb/opmode_chk_sva.sv */
`timescale 1ns/1ps
// ----------------
// Port checker
// ----------------
module opmode_chk
   import opmode_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire opmode_pkg::bus_req_type busReq,
   input wire logic [7:0] rdata,
   // External bus
   input wire logic xferStart,
   input wire logic xferWide,
   input wire logic [15:0] xferAddr,
   input wire logic [15:0] xferData,
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portBOut,
   input wire logic portAOe,
   input wire logic portBOe,
   input wire logic xferBusy,
   // Configuration
   input wire opmode_pkg::mode_cfg_type modeCfg,
   input wire logic cpuHalt,
   input wire logic background_debug_mode,
   input wire logic portAbInMap,
   input wire logic portEInMap,
   input wire logic portKInMap,
   input wire logic clock_stretch_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Accepted transfer start
   wire go = xferStart && !xferBusy && !modeCfg.singleChip && !modeCfg.periph;
   // Settled after reset
   sequence calm;
      (!sys_rst)[*6];
   endsequence
   // Narrow two-byte phases
   sequence narrowHi;
      ({portAOut, portBOut} == $past(xferAddr)) && portAOe ##1 portAOut == $past(xferData[15:8], 2);
   endsequence
   sequence narrowLo;
      {portAOut, portBOut} == $past(xferAddr, 3) + 16'h0001 ##1 portAOut == $past(xferData[7:0], 4) ##1 !portAOe;
   endsequence
   chk_single_no_bus: assert property (modeCfg.singleChip |-> !portAOe && !portBOe)
      else $error("bus driven in single-chip mode");
   chk_periph_halt: assert property (modeCfg.periph && $past(modeCfg.periph) |-> cpuHalt)
      else $error("processor running in peripheral mode");
   chk_periph_fixed: assert property ((!sys_rst)[*4] |=> $stable(modeCfg.periph))
      else $error("peripheral mode changed outside reset");
   chk_wide_xfer: assert property (go && modeCfg.wideBus |=>
      {portAOut, portBOut} == $past(xferAddr) && portBOe ##1 {portAOut, portBOut} == $past(xferData, 2)
      ##1 !portAOe && !portBOe) else $error("wide transfer phases wrong");
   chk_narrow_xfer: assert property (go && modeCfg.narrowBus && xferWide |=> narrowHi ##1 narrowLo)
      else $error("narrow transfer phases wrong");
   chk_ab_map: assert property (calm ##0 $past(modeCfg, 2) == modeCfg |-> portAbInMap == modeCfg.singleChip)
      else $error("port A and B map wrong");
   chk_ek_periph: assert property (calm ##0 modeCfg.periph |-> !portEInMap && !portKInMap)
      else $error("port E or K mapped in peripheral mode");
   chk_stretch_exp: assert property (calm ##0 $past(modeCfg, 2) == modeCfg ##0
      (modeCfg.wideBus || modeCfg.narrowBus) && !modeCfg.periph |-> clock_stretch_enable)
      else $error("stretch enable low in expanded mode");
   chk_debug_ss: assert property (calm ##0 modeCfg.singleChip && modeCfg.special |-> background_debug_mode)
      else $error("debug inactive in special single-chip");
   chk_unmapped_rd: assert property (busReq.rd && busReq.addr == ADDR_MODE && modeCfg.periph |=> rdata == 8'h00)
      else $error("mode register visible in peripheral mode");
endmodule
bind operating_mode_select opmode_chk chk_u (.clk, .sys_rst, .busReq, .rdata, .xferStart, .xferWide, .xferAddr,
   .xferData, .portAOut, .portBOut, .portAOe, .portBOe, .xferBusy, .modeCfg, .cpuHalt, .background_debug_mode,
   .portAbInMap, .portEInMap, .portKInMap, .clock_stretch_enable);

/* File: tb/bus_device_model.sv */
`timescale 1ns/1ps
// ----------------
// External bus device
// ----------------
module bus_device_model (
   // Clock
   input wire logic clk,
   // Bus pins
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portBOut,
   input wire logic portAOe
);
   logic [15:0] seen[$];
   // Latch each phase the block drives
   always @(posedge clk) begin
      if (portAOe === 1'h1) begin
         seen.push_back({portAOut, portBOut});
      end
   end
endmodule

/* File: tb/test_operating_mode_select.sv */
`timescale 1ns/1ps
module test_operating_mode_select;
   import opmode_pkg::*;
   // ----------------
   // Signals
   // ----------------
   typedef struct {logic [2:0] s; logic [7:0] st, msk, mr;} row_type;
   logic clk = 0, sys_rst = 1, background_strap_pin = 0, mode_select_b = 0, mode_select_a = 0;
   bus_req_type busReq = '0;
   logic debugEnableCmd = 0, debugActivateCmd = 0, xferStart = 0, xferWide = 0;
   logic [15:0] xferAddr = 0, xferData = 0;
   logic [7:0] rdata, portAOut, portBOut, v;
   logic portAOe, portBOe, xferBusy, cpuHalt, background_debug_mode;
   logic portAbInMap, portEInMap, portKInMap, clock_stretch_enable;
   mode_cfg_type modeCfg;
   int failures = 0, tests_run = 0;
   row_type rows[8] = '{'{3'h4, 8'he1, 8'hff, 8'h90}, '{3'h5, 8'hc2, 8'hff, 8'hb0}, '{3'h6, 8'h0c, 8'hff, 8'h00},
      '{3'h7, 8'hc4, 8'hff, 8'hf0}, '{3'h0, 8'hf1, 8'hff, 8'h13}, '{3'h1, 8'h02, 8'hff, 8'h33},
      '{3'h2, 8'h0c, 8'hff, 8'h00}, '{3'h3, 8'h04, 8'hff, 8'h73}};
   always #12.5 clk = ~clk;
   operating_mode_select dut_u (.clk, .sys_rst, .background_strap_pin, .mode_select_b, .mode_select_a, .busReq,
      .rdata, .debugEnableCmd, .debugActivateCmd, .xferStart, .xferWide, .xferAddr, .xferData, .portAOut,
      .portBOut, .portAOe, .portBOe, .xferBusy, .modeCfg, .cpuHalt, .background_debug_mode, .portAbInMap,
      .portEInMap, .portKInMap, .clock_stretch_enable);
   bus_device_model bus_u (.clk, .portAOut, .portBOut, .portAOe);
   // ----------------
   // Tasks
   // ----------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic boot(input logic [2:0] s);
      @(posedge clk);
      sys_rst <= 1'h1;
      {background_strap_pin, mode_select_b, mode_select_a} <= s;
      repeat (16) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{a, d, 1'h1, 1'h0};
      @(posedge clk);
      busReq <= '0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      busReq <= '{a, 8'h00, 1'h0, 1'h1};
      @(posedge clk);
      busReq <= '0;
      #1 v = rdata;
   endtask
   task automatic xfer(input logic [15:0] a, input logic [15:0] d);
      bus_u.seen.delete();
      @(posedge clk);
      xferStart <= 1'h1;
      xferWide <= 1'h1;
      xferAddr <= a;
      xferData <= d;
      @(posedge clk);
      xferStart <= 1'h0;
      repeat (8) @(posedge clk);
   endtask
   task automatic pulse(input logic en);
      @(posedge clk);
      {debugEnableCmd, debugActivateCmd} <= {en, !en};
      @(posedge clk);
      {debugEnableCmd, debugActivateCmd} <= 2'h0;
   endtask
   // ----------------
   // Sequence
   // ----------------
   initial begin
      for (int i = 0; i < 8; i++) begin
         boot(rows[i].s);
         rd(ADDR_STATUS);
         check("status", v & rows[i].msk, rows[i].st);
         rd(ADDR_MODE);
         check("mode", v, rows[i].mr);
      end
      boot(3'h4);
      xfer(16'h1234, 16'h5678);
      check("single bus", 16'(bus_u.seen.size()), 16'h0000);
      wr(ADDR_MODE, 8'hb0);
      wr(ADDR_MODE, 8'hf0);
      rd(ADDR_MODE);
      check("write once", v, 8'hb0);
      xfer(16'h12ff, 16'habcd);
      check("phase0", bus_u.seen[0], 16'h12ff);
      check("phase1", bus_u.seen[1] & 16'hff00, 16'hab00);
      check("phase2", bus_u.seen[2], 16'h1300);
      check("phase3", bus_u.seen[3] & 16'hff00, 16'hcd00);
      pulse(1'h0);
      rd(ADDR_STATUS);
      check("debug early", v[BIT_DEBUG], 1'h0);
      pulse(1'h1);
      pulse(1'h0);
      rd(ADDR_STATUS);
      check("debug on", v[BIT_DEBUG], 1'h1);
      boot(3'h0);
      wr(ADDR_MODE, 8'h33);
      rd(ADDR_MODE);
      check("first ignored", v, 8'h13);
      wr(ADDR_MODE, 8'h53);
      rd(ADDR_MODE);
      check("no periph", v, 8'h13);
      wr(ADDR_MODE, 8'h73);
      rd(ADDR_MODE);
      check("special write", v, 8'h73);
      xfer(16'h4321, 16'h8765);
      check("wide addr", bus_u.seen[0], 16'h4321);
      check("wide data", bus_u.seen[1], 16'h8765);
      wr(ADDR_MODE, 8'hf3);
      rd(ADDR_MODE);
      check("to normal", v, 8'hf3);
      boot(3'h2);
      wr(ADDR_MODE, 8'h73);
      rd(ADDR_STATUS);
      check("periph kept", v, 8'h0c);
      check("halt", cpuHalt, 1'h1);
      end_of_test;
   end
   // Hang guard
   initial begin
      #200000;
      failures++;
      end_of_test;
   end
endmodule
